// ---- rtl/accel_event_regs.vh ----
// Register map, field positions, reset values and timing counts for the accelerometer event and self-test control
// What this block does
// - A tap on an axis's positive face reports negative sign; opposite face positive.
// - Lower output rates come from decimating one common internal sample rate.
// - Activity, free-fall and tap detect use unfiltered samples, and are disabled while improved tap is on.
// - With link set, activity is sought only after inactivity was detected.
// - Autosleep is not entered while an activity interrupt is still pending.
// - Activity and tap status register carries a bit showing the part is asleep.
// - While asleep, the new-sample-ready interrupt is suppressed.
// - Full resolution at widest range scales samples at 3.9 mg per LSB.
// - Self-test stimulus applied while format bit 7 is set, removed when cleared.
`ifndef ACCEL_EVENT_REGS_VH
`define ACCEL_EVENT_REGS_VH

// Register offsets
`define ADDR_ACTIVITY_TAP_STATUS 6'h2b
`define ADDR_RATE_POWER 6'h2c
`define ADDR_INT_CAUSE 6'h30
`define ADDR_FORMAT 6'h31
// Own control registers
`define ADDR_ACT_THRESH 6'h24
`define ADDR_INACT_THRESH 6'h25
`define ADDR_INACT_TIME 6'h26
`define ADDR_ACT_CTL 6'h27
`define ADDR_TAP_THRESH 6'h1d
`define ADDR_TAP_CTL 6'h2a
`define ADDR_FF_THRESH 6'h28
`define ADDR_POWER_CTL 6'h2d
`define ADDR_INT_ENABLE 6'h2e

// Field positions
`define BIT_LOW_POWER 4
`define BIT_SELF_TEST 7
`define BIT_FULL_RES 3
`define BIT_ASLEEP 3
`define BIT_LINK 5
`define BIT_AUTOSLEEP 4
`define BIT_IMPROVED_TAP 3
`define BIT_SUPPRESS 4
`define BIT_INT_READY 7
`define BIT_INT_TAP 6
`define BIT_INT_ACT 4
`define BIT_INT_INACT 3
`define BIT_INT_FF 2

// Reset values
`define RST_RATE_POWER 8'h0a
`define RST_FORMAT 8'h00
`define RST_ZERO 8'h00

// Timing: common internal sample rate, counted in 100 MHz system clocks
`define SAMPLE_RATE_HZ 40000
`define CLK_RATE_HZ 100000000
`define SAMPLE_CYCLES (`CLK_RATE_HZ / `SAMPLE_RATE_HZ)
// Self-test stimulus in counts, full resolution 3.9 mg per LSB
`define SELF_TEST_SHIFT 16'sd100

// Serial link
`define SPI_FRAME_BITS 16
`endif

// ---- rtl/link_sync.v ----
// Two-stage synchroniser for a single level from outside the clock domain
`timescale 1ns/1ps
module link_sync #(
   // Level held through reset; matches the pin's idle level so no false edge follows reset
   parameter [0:0] RST_LEVEL = 1'b0
) (
   // Clock and reset
   input wire sys_clk,
   input wire rstn,
   // Level in and out
   input wire async_in,
   output reg sync_out
);
   reg meta_reg;

   // First stage read only by second stage
   always @(posedge sys_clk) begin
      if (!rstn) begin
         meta_reg <= RST_LEVEL;
         sync_out <= RST_LEVEL;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// ---- rtl/axis_detect.v ----
// One axis: raw magnitude compares for activity, inactivity, free-fall and tap sign
`timescale 1ns/1ps
module axis_detect (
   // Unfiltered sample of this axis, signed counts
   input wire [15:0] raw_sample,
   // Thresholds in steps of 16 counts
   input wire [7:0] act_thresh,
   input wire [7:0] inact_thresh,
   input wire [7:0] ff_thresh,
   input wire [7:0] tap_thresh,
   // Compare results
   output wire above_act,
   output wire below_inact,
   output wire below_ff,
   output wire above_tap,
   output wire tap_negative
);
   wire [15:0] mag;

   // Magnitude of raw sample; threshold LSB is 16 counts
   assign mag = raw_sample[15] ? (~raw_sample + 16'h0001) : raw_sample;
   assign above_act = mag > {4'h0, act_thresh, 4'h0};
   assign below_inact = mag <= {4'h0, inact_thresh, 4'h0};
   assign below_ff = mag <= {4'h0, ff_thresh, 4'h0};
   assign above_tap = mag > {4'h0, tap_thresh, 4'h0};
   // Positive-face strike gives negative acceleration, reported as negative sign
   assign tap_negative = raw_sample[15];
endmodule

// ---- rtl/accel_event_ctrl.v ----
// Accelerometer event, sleep and self-test control with SPI register access
`timescale 1ns/1ps
`include "accel_event_regs.vh"
module accel_event_ctrl (
   // Clock and reset
   input wire sys_clk,
   input wire rstn,
   // Serial register port, SPI mode 3
   input wire spi_sclk,
   input wire spi_cs_n,
   input wire spi_mosi,
   output reg spi_miso,
   output reg spi_miso_oe,
   // Unfiltered samples from sensor front end, on sys_clk
   input wire [15:0] raw_x,
   input wire [15:0] raw_y,
   input wire [15:0] raw_z,
   // Interrupt pin
   output reg int_out,
   // Self-test stimulus and scaled output
   output reg self_test_drive,
   output reg [15:0] out_x,
   output reg out_ready
);
   // Synchronised link pins
   wire sclk_s;
   wire cs_n_s;
   wire mosi_s;
   // Clock and select idle high, so they leave reset high: no false select or edge
   link_sync #(.RST_LEVEL(1'b1)) u_sync_sclk (.sys_clk(sys_clk), .rstn(rstn), .async_in(spi_sclk),
      .sync_out(sclk_s));
   link_sync #(.RST_LEVEL(1'b1)) u_sync_cs (.sys_clk(sys_clk), .rstn(rstn), .async_in(spi_cs_n),
      .sync_out(cs_n_s));
   link_sync u_sync_mosi (.sys_clk(sys_clk), .rstn(rstn), .async_in(spi_mosi), .sync_out(mosi_s));

   // Registers
   reg [7:0] rate_power_reg;
   reg [7:0] format_reg;
   reg [7:0] act_thresh_reg;
   reg [7:0] inact_thresh_reg;
   reg [7:0] inact_time_reg;
   reg [7:0] act_ctl_reg;
   reg [7:0] tap_thresh_reg;
   reg [7:0] tap_ctl_reg;
   reg [7:0] ff_thresh_reg;
   reg [7:0] power_ctl_reg;
   reg [7:0] int_enable_reg;
   reg [7:0] int_cause_reg;
   reg [7:0] tap_status_reg;
   reg asleep_reg;
   reg act_armed_reg;

   // Serial engine
   reg sclk_d_reg;
   reg [4:0] bit_cnt_reg;
   reg [15:0] shift_reg;
   reg [7:0] rd_data_reg;
   reg [5:0] addr_reg;
   reg rd_reg;
   wire sclk_rise;
   wire sclk_fall;
   assign sclk_rise = sclk_s & ~sclk_d_reg;
   assign sclk_fall = ~sclk_s & sclk_d_reg;

   // Register read mux
   reg [7:0] rd_mux;
   always @* begin
      case (addr_reg)
         `ADDR_ACTIVITY_TAP_STATUS: rd_mux = tap_status_reg;
         `ADDR_RATE_POWER: rd_mux = rate_power_reg;
         `ADDR_INT_CAUSE: rd_mux = int_cause_reg;
         `ADDR_FORMAT: rd_mux = format_reg;
         `ADDR_ACT_THRESH: rd_mux = act_thresh_reg;
         `ADDR_INACT_THRESH: rd_mux = inact_thresh_reg;
         `ADDR_INACT_TIME: rd_mux = inact_time_reg;
         `ADDR_ACT_CTL: rd_mux = act_ctl_reg;
         `ADDR_TAP_THRESH: rd_mux = tap_thresh_reg;
         `ADDR_TAP_CTL: rd_mux = tap_ctl_reg;
         `ADDR_FF_THRESH: rd_mux = ff_thresh_reg;
         `ADDR_POWER_CTL: rd_mux = power_ctl_reg;
         `ADDR_INT_ENABLE: rd_mux = int_enable_reg;
         default: rd_mux = 8'h00;
      endcase
   end

   // Frame: bit15 read flag, bit14 unused, bits13:8 address, bits7:0 data
   wire addr_done;
   wire frame_done;
   wire wr_strobe;
   wire rd_clear;
   assign addr_done = ~cs_n_s & sclk_rise & (bit_cnt_reg == 5'd7);
   assign frame_done = ~cs_n_s & sclk_rise & (bit_cnt_reg == 5'd15);
   assign wr_strobe = frame_done & ~rd_reg;
   // Clear fires at end of a read of the cause register only
   assign rd_clear = frame_done & rd_reg & (addr_reg == `ADDR_INT_CAUSE);

   // Shift engine; MISO driven only while selected
   always @(posedge sys_clk) begin
      if (!rstn) begin
         sclk_d_reg <= 1'b1;
         bit_cnt_reg <= 5'd0;
         shift_reg <= 16'h0000;
         rd_data_reg <= 8'h00;
         addr_reg <= 6'h00;
         rd_reg <= 1'b0;
         spi_miso <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_s;
         spi_miso_oe <= ~cs_n_s;
         if (cs_n_s) begin
            bit_cnt_reg <= 5'd0;
            spi_miso <= 1'b0;
         end else begin
            if (sclk_rise) begin
               shift_reg <= {shift_reg[14:0], mosi_s};
               bit_cnt_reg <= bit_cnt_reg + 5'd1;
               if (addr_done) begin
                  rd_reg <= shift_reg[6];
                  addr_reg <= {shift_reg[4:0], mosi_s};
               end
            end
            if (sclk_fall && bit_cnt_reg == 5'd8) begin
               rd_data_reg <= {rd_mux[6:0], 1'b0};
               spi_miso <= rd_mux[7];
            end else if (sclk_fall && bit_cnt_reg > 5'd8) begin
               spi_miso <= rd_data_reg[7];
               rd_data_reg <= {rd_data_reg[6:0], 1'b0};
            end
         end
      end
   end

   // Per-axis raw detectors, shared by activity, free-fall and tap
   wire [2:0] above_act;
   wire [2:0] below_inact;
   wire [2:0] below_ff;
   wire [2:0] above_tap;
   wire [2:0] tap_neg;
   axis_detect u_det_x (.raw_sample(raw_x), .act_thresh(act_thresh_reg), .inact_thresh(inact_thresh_reg),
      .ff_thresh(ff_thresh_reg), .tap_thresh(tap_thresh_reg), .above_act(above_act[0]),
      .below_inact(below_inact[0]), .below_ff(below_ff[0]), .above_tap(above_tap[0]), .tap_negative(tap_neg[0]));
   axis_detect u_det_y (.raw_sample(raw_y), .act_thresh(act_thresh_reg), .inact_thresh(inact_thresh_reg),
      .ff_thresh(ff_thresh_reg), .tap_thresh(tap_thresh_reg), .above_act(above_act[1]),
      .below_inact(below_inact[1]), .below_ff(below_ff[1]), .above_tap(above_tap[1]), .tap_negative(tap_neg[1]));
   axis_detect u_det_z (.raw_sample(raw_z), .act_thresh(act_thresh_reg), .inact_thresh(inact_thresh_reg),
      .ff_thresh(ff_thresh_reg), .tap_thresh(tap_thresh_reg), .above_act(above_act[2]),
      .below_inact(below_inact[2]), .below_ff(below_ff[2]), .above_tap(above_tap[2]), .tap_negative(tap_neg[2]));

   // Common internal sample tick; lower rates decimate it
   localparam [31:0] TICK_LOAD = `SAMPLE_CYCLES - 1;
   reg [15:0] tick_cnt_reg;
   reg [9:0] decim_cnt_reg;
   reg [9:0] decim_len;
   wire base_tick;
   wire out_tick;
   assign base_tick = (tick_cnt_reg == 16'd0);
   always @* begin
      case (rate_power_reg[3:0])
         4'hf: decim_len = 10'd0;
         4'he: decim_len = 10'd1;
         4'hd: decim_len = 10'd3;
         4'hc: decim_len = 10'd7;
         4'hb: decim_len = 10'd15;
         4'ha: decim_len = 10'd31;
         4'h9: decim_len = 10'd63;
         4'h8: decim_len = 10'd127;
         4'h7: decim_len = 10'd255;
         4'h6: decim_len = 10'd511;
         default: decim_len = 10'd1023;
      endcase
   end
   assign out_tick = base_tick & (decim_cnt_reg >= decim_len);

   always @(posedge sys_clk) begin
      if (!rstn) begin
         tick_cnt_reg <= 16'd0;
         decim_cnt_reg <= 10'd0;
      end else begin
         tick_cnt_reg <= base_tick ? TICK_LOAD[15:0] : tick_cnt_reg - 16'd1;
         if (out_tick) begin
            decim_cnt_reg <= 10'd0;
         end else if (base_tick) begin
            decim_cnt_reg <= decim_cnt_reg + 10'd1;
         end
      end
   end

   // Event conditions from raw samples; activity, free-fall and tap only when improved tap is off
   wire raw_path;
   wire act_en;
   wire link_on;
   wire act_hit;
   wire inact_now;
   wire ff_hit;
   wire tap_hit;
   assign raw_path = ~tap_ctl_reg[`BIT_IMPROVED_TAP];
   assign act_en = |(act_ctl_reg[2:0] & above_act);
   assign link_on = power_ctl_reg[`BIT_LINK];
   // With link, activity is only looked for once inactivity was seen
   assign act_hit = base_tick & raw_path & act_en & (~link_on | act_armed_reg);
   assign inact_now = &(below_inact | ~act_ctl_reg[2:0]);
   assign ff_hit = base_tick & raw_path & (&below_ff);
   assign tap_hit = base_tick & raw_path & (|(above_tap & tap_ctl_reg[2:0]));

   // Inactivity timer in output samples
   reg [7:0] inact_cnt_reg;
   wire inact_hit;
   assign inact_hit = out_tick & inact_now & (inact_cnt_reg >= inact_time_reg) & (~link_on | ~act_armed_reg);

   // Event flags, sleep and link state
   wire autosleep_ok;
   // Pending activity blocks autosleep
   assign autosleep_ok = ~int_cause_reg[`BIT_INT_ACT];
   always @(posedge sys_clk) begin
      if (!rstn) begin
         int_cause_reg <= `RST_ZERO;
         tap_status_reg <= `RST_ZERO;
         asleep_reg <= 1'b0;
         act_armed_reg <= 1'b0;
         inact_cnt_reg <= 8'h00;
      end else begin
         if (out_tick) begin
            inact_cnt_reg <= inact_now ? ((inact_cnt_reg == 8'hff) ? inact_cnt_reg : inact_cnt_reg + 8'h01) : 8'h00;
         end
         if (inact_hit) begin
            act_armed_reg <= 1'b1;
            if (power_ctl_reg[`BIT_AUTOSLEEP] && autosleep_ok) begin
               asleep_reg <= 1'b1;
            end
         end
         if (act_hit) begin
            act_armed_reg <= 1'b0;
            asleep_reg <= 1'b0;
         end
         // Set wins over the read clear
         int_cause_reg[`BIT_INT_ACT] <= act_hit | (int_cause_reg[`BIT_INT_ACT] & ~rd_clear);
         int_cause_reg[`BIT_INT_INACT] <= inact_hit | (int_cause_reg[`BIT_INT_INACT] & ~rd_clear);
         int_cause_reg[`BIT_INT_FF] <= ff_hit | int_cause_reg[`BIT_INT_FF];
         int_cause_reg[`BIT_INT_TAP] <= tap_hit | int_cause_reg[`BIT_INT_TAP];
         // Ready suppressed in sleep so no notification reaches the host
         int_cause_reg[`BIT_INT_READY] <= out_tick & ~asleep_reg;
         int_cause_reg[5] <= 1'b0;
         int_cause_reg[1:0] <= 2'b00;
         // Latest tap axes kept with their sign; never cleared, overwritten by each tap
         if (tap_hit) begin
            tap_status_reg[2:0] <= above_tap & tap_ctl_reg[2:0];
            tap_status_reg[6:4] <= tap_neg;
         end
         tap_status_reg[`BIT_ASLEEP] <= asleep_reg;
         tap_status_reg[7] <= 1'b0;
      end
   end

   // Register writes; cause and status are read only
   always @(posedge sys_clk) begin
      if (!rstn) begin
         rate_power_reg <= `RST_RATE_POWER;
         format_reg <= `RST_FORMAT;
         act_thresh_reg <= `RST_ZERO;
         inact_thresh_reg <= `RST_ZERO;
         inact_time_reg <= `RST_ZERO;
         act_ctl_reg <= `RST_ZERO;
         tap_thresh_reg <= `RST_ZERO;
         tap_ctl_reg <= `RST_ZERO;
         ff_thresh_reg <= `RST_ZERO;
         power_ctl_reg <= `RST_ZERO;
         int_enable_reg <= `RST_ZERO;
      end else if (wr_strobe) begin
         case (addr_reg)
            `ADDR_RATE_POWER: rate_power_reg <= {3'b000, shift_reg[3:0], mosi_s};
            `ADDR_FORMAT: format_reg <= {shift_reg[6:0], mosi_s};
            `ADDR_ACT_THRESH: act_thresh_reg <= {shift_reg[6:0], mosi_s};
            `ADDR_INACT_THRESH: inact_thresh_reg <= {shift_reg[6:0], mosi_s};
            `ADDR_INACT_TIME: inact_time_reg <= {shift_reg[6:0], mosi_s};
            `ADDR_ACT_CTL: act_ctl_reg <= {shift_reg[6:0], mosi_s};
            `ADDR_TAP_THRESH: tap_thresh_reg <= {shift_reg[6:0], mosi_s};
            `ADDR_TAP_CTL: tap_ctl_reg <= {shift_reg[6:0], mosi_s};
            `ADDR_FF_THRESH: ff_thresh_reg <= {shift_reg[6:0], mosi_s};
            `ADDR_POWER_CTL: power_ctl_reg <= {shift_reg[6:0], mosi_s};
            `ADDR_INT_ENABLE: int_enable_reg <= {shift_reg[6:0], mosi_s};
            default: ;
         endcase
      end
   end

   // Output sample path with self-test stimulus and resolution scaling
   reg [15:0] scaled;
   wire [15:0] stim_x;
   assign stim_x = self_test_drive ? (raw_x + `SELF_TEST_SHIFT) : raw_x;
   always @* begin
      // Full resolution keeps 3.9 mg/LSB; fixed mode drops bits with range
      if (format_reg[`BIT_FULL_RES]) begin
         scaled = stim_x;
      end else begin
         case (format_reg[1:0])
            2'd0: scaled = stim_x;
            2'd1: scaled = {stim_x[15], stim_x[15:1]};
            2'd2: scaled = {{2{stim_x[15]}}, stim_x[15:2]};
            default: scaled = {{3{stim_x[15]}}, stim_x[15:3]};
         endcase
      end
   end

   always @(posedge sys_clk) begin
      if (!rstn) begin
         self_test_drive <= 1'b0;
         out_x <= 16'h0000;
         out_ready <= 1'b0;
         int_out <= 1'b0;
      end else begin
         self_test_drive <= format_reg[`BIT_SELF_TEST];
         out_ready <= out_tick & ~asleep_reg;
         if (out_tick) begin
            out_x <= scaled;
         end
         int_out <= |(int_cause_reg & int_enable_reg);
      end
   end
endmodule

// ---- test/accel_event_ctrl_sva.sv ----
// Port-level assertions for the accelerometer event and self-test control block
`timescale 1ns/1ps
module accel_event_ctrl_sva (
   // Clock and reset
   input wire sys_clk,
   input wire rstn,
   // Serial port
   input wire spi_sclk,
   input wire spi_cs_n,
   input wire spi_miso,
   input wire spi_miso_oe,
   // Event and sample outputs
   input wire int_out,
   input wire self_test_drive,
   input wire out_ready
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   logic [4:0] cs_idle_reg;
   logic [3:0] sclk_high_reg;
   // Saturating counters, so a long idle gap cannot wrap back into range
   always @(posedge sys_clk) begin
      if (!rstn) begin
         cs_idle_reg <= 5'h00;
         sclk_high_reg <= 4'h0;
      end else begin
         cs_idle_reg <= !spi_cs_n ? 5'h00 : (cs_idle_reg == 5'h1f ? cs_idle_reg : cs_idle_reg + 5'h01);
         sclk_high_reg <= !spi_sclk ? 4'h0 : (sclk_high_reg == 4'hf ? sclk_high_reg : sclk_high_reg + 4'h1);
      end
   end
   a_reset_quiet: assert property (disable iff (1'b0)
      !rstn |=> !int_out && !out_ready && !self_test_drive && !spi_miso_oe) else $error("outputs not quiet in reset");
   a_oe_idle: assert property (cs_idle_reg >= 5'h06 |-> !spi_miso_oe) else $error("miso driven while deselected");
   a_oe_select: assert property ($fell(spi_cs_n) |-> ##[1:5] spi_miso_oe) else $error("miso not driven after select");
   a_oe_hold: assert property (spi_miso_oe && !spi_cs_n |=> spi_miso_oe) else $error("miso dropped inside frame");
   a_miso_on_fall: assert property ($changed(spi_miso) && !spi_cs_n && $past(spi_cs_n, 6) == 1'b0
      |-> sclk_high_reg < 4'h6) else $error("miso moved without a clock fall");
   a_ready_gap: assert property (out_ready |=> !out_ready [*8]) else $error("ready pulse too long or too close");
   a_st_by_write: assert property ($changed(self_test_drive) |-> cs_idle_reg < 5'h10) else $error("stimulus moved without a frame");
   a_int_after_reset: assert property ($rose(rstn) |-> !int_out [*3]) else $error("interrupt raised out of reset");
endmodule
bind accel_event_ctrl accel_event_ctrl_sva chk (
   .sys_clk(sys_clk),
   .rstn(rstn),
   .spi_sclk(spi_sclk),
   .spi_cs_n(spi_cs_n),
   .spi_miso(spi_miso),
   .spi_miso_oe(spi_miso_oe),
   .int_out(int_out),
   .self_test_drive(self_test_drive),
   .out_ready(out_ready)
);

// ---- test/spi_host_model.sv ----
// Host-side serial master model sending register frames to the device
`timescale 1ns/1ps
module spi_host_model (
   // Clock for the result strobe
   input wire sys_clk,
   // Serial port, mode 3
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire spi_miso,
   // Read result
   output logic [7:0] rd_data,
   output logic rd_valid
);
   // Idle levels: clock high, deselected
   initial begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      rd_data = 8'h00;
      rd_valid = 1'b0;
   end
   // One 16-bit frame MSB first; data moves on falls, is taken on rises
   task automatic xfer(input logic rd, input logic [5:0] addr, input logic [7:0] data);
      logic [15:0] frame;
      frame = {rd, 1'b0, addr, data};
      @(posedge sys_clk);
      #3 spi_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         #80 spi_sclk = 1'b0;
         spi_mosi = frame[i];
         #80 spi_sclk = 1'b1;
         if (i < 8) begin
            rd_data[i] = spi_miso;
         end
      end
      #80 spi_cs_n = 1'b1;
      // Released line flips, so a stale bit never looks like data
      spi_mosi = ~spi_mosi;
      @(posedge sys_clk);
      rd_valid <= rd;
      @(posedge sys_clk);
      rd_valid <= 1'b0;
      #160;
   endtask
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the accelerometer event and self-test control block
`timescale 1ns/1ps
`include "accel_event_regs.vh"
module testbench;
   logic sys_clk;
   logic rstn;
   logic [15:0] raw_x;
   logic [15:0] raw_z;
   wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   wire int_out, self_test_drive, out_ready, rd_valid;
   wire [15:0] out_x;
   wire [7:0] rd_data;
   int bad_count = 0;
   int tests_run = 0;
   logic [15:0] exp_q[$];
   logic [15:0] note;
   logic [15:0] s0;
   logic [15:0] s1;
   logic [15:0] cnt;
   logic [7:0] v;

   accel_event_ctrl uut (.sys_clk(sys_clk), .rstn(rstn), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .raw_x(raw_x), .raw_y(raw_z),
      .raw_z(raw_z), .int_out(int_out), .self_test_drive(self_test_drive), .out_x(out_x), .out_ready(out_ready));
   spi_host_model host (.sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .rd_data(rd_data), .rd_valid(rd_valid));

   // 100 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      tests_run++;
      if (seen !== expv) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask

   task automatic final_report();
      $display("compares %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      host.xfer(1'b0, a, d);
   endtask

   // Mask in the top byte, expected value below; the watcher compares
   task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back({m, e});
      host.xfer(1'b1, a, 8'h00);
   endtask

   // Bounded wait for a sample tick or the interrupt pin
   task automatic wait_sig(input logic use_int);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
         if (n > 12000) begin
            bad_count++;
            final_report();
         end
      end while ((use_int ? int_out : out_ready) !== 1'b1);
   endtask

   // Watcher: each finished read takes the oldest note off the queue
   always @(posedge sys_clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check({8'h00, rd_data}, 16'hffff);
         end else begin
            note = exp_q.pop_front();
            check({8'h00, rd_data & note[15:8]}, {8'h00, note[7:0] & note[15:8]});
         end
      end
   end

   // Main sequence
   initial begin
      rstn = 1'b0;
      raw_x = 16'h0000;
      raw_z = 16'h0000;
      v = 8'($urandom(32'hc4252e7d));
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      // Reset values, unmapped place, read-back
      rd(`ADDR_RATE_POWER, `RST_RATE_POWER, 8'hff);
      rd(`ADDR_FORMAT, `RST_FORMAT, 8'hff);
      wr(6'h3f, 8'h5a);
      rd(6'h3f, 8'h00, 8'hff);
      wr(`ADDR_FORMAT, v & 8'h7f);
      rd(`ADDR_FORMAT, v & 8'h7f, 8'hff);
      wr(`ADDR_RATE_POWER, v | 8'h10);
      rd(`ADDR_RATE_POWER, v | 8'h10, 8'h1f);
      $display("test registers done");
      // Self-test at full rate, normal power, full resolution, widest range
      wr(`ADDR_RATE_POWER, 8'h0f);
      wr(`ADDR_FORMAT, 8'h0b);
      @(posedge sys_clk) raw_x <= {8'h00, v};
      s0 = 16'h0000;
      s1 = 16'h0000;
      // Equal sample counts off and on; settling samples thrown away
      repeat (2) begin
         wait_sig(1'b0);
         s0 = s0 + out_x;
      end
      wr(`ADDR_FORMAT, 8'h8b);
      check({15'h0000, self_test_drive}, 16'h0001);
      repeat (4) wait_sig(1'b0);
      repeat (2) begin
         wait_sig(1'b0);
         s1 = s1 + out_x;
      end
      check((s1 - s0) >> 1, `SELF_TEST_SHIFT);
      wr(`ADDR_FORMAT, 8'h0b);
      check({15'h0000, self_test_drive}, 16'h0000);
      $display("test self_test done");
      // Link and autosleep: activity with link off disarms, then sleep on inactivity, wake on activity
      wr(`ADDR_ACT_THRESH, 8'h10);
      wr(`ADDR_INACT_THRESH, 8'h10);
      wr(`ADDR_INACT_TIME, 8'h01);
      @(posedge sys_clk) raw_x <= 16'h0400 + {8'h00, v};
      wr(`ADDR_ACT_CTL, 8'h07);
      rd(`ADDR_INT_CAUSE, 8'h00, 8'h00);
      wr(`ADDR_INT_ENABLE, 8'h18);
      wait_sig(1'b1);
      rd(`ADDR_INT_CAUSE, 8'h10, 8'h18);
      @(posedge sys_clk) raw_x <= 16'h0000;
      wr(`ADDR_POWER_CTL, 8'h30);
      rd(`ADDR_INT_CAUSE, 8'h00, 8'h00);
      wait_sig(1'b1);
      rd(`ADDR_ACTIVITY_TAP_STATUS, 8'h08, 8'h08);
      cnt = 16'h0000;
      repeat (3000) begin
         @(posedge sys_clk);
         #1;
         cnt = cnt + {15'h0000, out_ready === 1'b1};
      end
      check(cnt, 16'h0000);
      rd(`ADDR_INT_CAUSE, 8'h08, 8'h18);
      check({15'h0000, int_out}, 16'h0000);
      @(posedge sys_clk) raw_x <= 16'h0400 + {8'h00, v};
      wait_sig(1'b1);
      rd(`ADDR_ACTIVITY_TAP_STATUS, 8'h00, 8'h08);
      @(posedge sys_clk) raw_x <= 16'h0000;
      wait_sig(1'b0);
      wait_sig(1'b0);
      rd(`ADDR_ACTIVITY_TAP_STATUS, 8'h00, 8'h08);
      wr(`ADDR_INT_CAUSE, 8'h00);
      rd(`ADDR_INT_CAUSE, 8'h18, 8'h18);
      rd(`ADDR_INT_CAUSE, 8'h00, 8'h18);
      $display("test sleep done");
      // Tap sign: negative sample is a strike on the positive face
      wr(`ADDR_TAP_THRESH, 8'h10);
      wr(`ADDR_TAP_CTL, 8'h01);
      for (int k = 0; k < 2; k++) begin
         @(posedge sys_clk) raw_x <= (k == 0) ? 16'hfb00 : 16'h0500;
         // Strike held over a sample tick so the detector sees it
         wait_sig(1'b0);
         @(posedge sys_clk) raw_x <= 16'h0000;
         repeat (20) @(posedge sys_clk);
         rd(`ADDR_ACTIVITY_TAP_STATUS, (k == 0) ? 8'h10 : 8'h00, 8'h10);
      end
      $display("test tap_sign done");
      final_report();
   end
endmodule
